/* File: hw/dfts_pkg.sv */
// Purpose: Constants and types for the drive fault trip supervisor.
// Assumes: Sensor words are already scaled digital values.
// Notes: Currents are in 1/100 of inverter rated current; volts in 1 V.
package dfts_pkg;
  localparam int CUR_W = 12;
  localparam int VOLT_W = 10;
  localparam int CODE_W = 4;
  localparam logic [CUR_W-1:0] OC_LIMIT = 12'h0C8;
  localparam logic [CUR_W-1:0] OL_LIMIT = 12'h096;
  localparam logic [CUR_W-1:0] IMB_LIMIT = 12'h032;
  localparam logic [CUR_W-1:0] PH_OPEN_LIMIT = 12'h005;
  localparam logic [VOLT_W-1:0] OV_LIMIT = 10'h190;
  localparam logic [VOLT_W-1:0] UV_LIMIT = 10'h0B4;
  localparam logic [4:0] FUNC_EXT_NO = 5'h12;
  localparam logic [4:0] FUNC_EXT_NC = 5'h13;
  localparam int N_MFI = 5;
  localparam int CLK_HZ = 100000000;
  localparam int TICK_NS = 100000000;
  localparam int TICK_CYC = TICK_NS / (1000000000 / CLK_HZ);
  localparam int OL_TIME_S = 60;
  localparam int OL_TICKS = OL_TIME_S * 10;
  localparam int RIPPLE_BASE_TICKS = 30;
  localparam logic [10:0] LOSS_WAIT_RST = 11'h00A;
  localparam logic [10:0] LOSS_WAIT_MIN = 11'h001;
  localparam logic [10:0] LOSS_WAIT_MAX = 11'h4B0;
  localparam int SYNC_W = 10;
  localparam int SYNC_FILL = 4;
  typedef enum logic [CODE_W-1:0] {
    FC_NONE, FC_HW, FC_INSTANT_CUT, FC_OVERCURRENT, FC_GROUND,
    FC_OVERVOLT, FC_UNDERVOLT, FC_OVERHEAT, FC_PHASE_LOSS,
    FC_RIPPLE, FC_INV_OVERLOAD, FC_MOTOR_OVERLOAD, FC_EXT_NO,
    FC_EXT_NC, FC_PARAM_SAVE
  } dfts_code_e;
  typedef enum logic [1:0] {
    LA_CONTINUE, LA_FREE_RUN, LA_DECEL, LA_RSVD
  } dfts_loss_e;
endpackage

/* File: hw/dfts_sync_if.sv */
// Purpose: Carrier between the top and its pin synchroniser.
// Assumes: One clock domain.
// Notes: raw carries pin levels, clean carries filtered levels.
`timescale 1ns/100ps
interface dfts_sync_if;
  logic [dfts_pkg::SYNC_W-1:0] raw;
  logic [dfts_pkg::SYNC_W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

/* File: hw/dfts_pin_sync.sv */
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Pins are asynchronous to sys_clk_i.
// Notes: A level is taken once stages two and three agree.
`timescale 1ns/100ps
module dfts_pin_sync
  import dfts_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Pins
  dfts_sync_if.sync pins
);
  logic [SYNC_W-1:0] s1_r, s2_r, s3_r, clean_r;
  logic [SYNC_W-1:0] clean_nxt;
  always_comb
  begin
    clean_nxt = clean_r;
    for (int i = 0; i < SYNC_W; i++)
    begin
      if (s2_r[i] == s3_r[i])
      begin
        clean_nxt[i] = s3_r[i];
      end
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      clean_r <= '0;
    end
    else
    begin
      s1_r <= pins.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      clean_r <= clean_nxt;
    end
  end
  assign pins.clean = clean_r;
endmodule // dfts_pin_sync

/* File: hw/dfts_top.sv */
// Purpose: Drive fault trip supervisor; compares sensors to limits, trips.
// Assumes: Sensor words synchronous to sys_clk_i; contacts are raw pins.
// Notes: Hardware fault survives srst_i only via por_i style power reset.
`timescale 1ns/100ps
module dfts_top
  import dfts_pkg::*;
(
  // Clock and resets
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic por_i,
  // Measured values
  input wire logic [CUR_W-1:0] phase_u_cur_i,
  input wire logic [CUR_W-1:0] phase_v_cur_i,
  input wire logic [CUR_W-1:0] phase_w_cur_i,
  input wire logic [VOLT_W-1:0] dc_bus_volt_i,
  input wire logic bus_ripple_i,
  input wire logic ground_fault_det_i,
  input wire logic heat_sink_over_i,
  // Internal status
  input wire logic param_save_fail_i,
  input wire logic cpu_fault_i,
  // Configuration
  input wire logic [CUR_W-1:0] motor_rated_current_setting_i,
  input wire logic ground_fault_en_i,
  input wire logic out_phase_loss_en_i,
  input wire logic [4:0] multifunction_input_select_i [N_MFI],
  input wire logic [1:0] loss_action_select_i,
  input wire logic [10:0] loss_wait_time_i,
  input wire logic freq_ref_remote_i,
  // Terminals, raw pins
  input wire logic emergency_cut_input_i,
  input wire logic forward_run_input_i,
  input wire logic reverse_run_input_i,
  input wire logic reset_terminal_i,
  input wire logic [N_MFI-1:0] mfi_pin_i,
  input wire logic freq_ref_present_i,
  // Outputs
  output logic gate_enable_o,
  output logic [CODE_W-1:0] fault_code_o,
  output logic fault_active_o,
  output logic ref_lost_o,
  output logic hold_last_freq_o,
  output logic decel_stop_o
);
  dfts_sync_if sif ();
  logic [SYNC_W-1:0] cl;
  assign sif.raw = {freq_ref_present_i, reset_terminal_i,
                    reverse_run_input_i, forward_run_input_i,
                    emergency_cut_input_i, mfi_pin_i};
  dfts_pin_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .pins(sif.sync)
  );
  assign cl = sif.clean;
  logic [N_MFI-1:0] mfi;
  logic estop, run_fx, run_rx, rst_req, ref_ok;
  assign mfi = cl[N_MFI-1:0];
  assign estop = cl[N_MFI];
  assign run_fx = cl[N_MFI+1];
  assign run_rx = cl[N_MFI+2];
  assign rst_req = cl[N_MFI+3];
  assign ref_ok = cl[N_MFI+4];

  function automatic logic mfi_hit(input logic [4:0] sel [N_MFI],
                                   input logic [N_MFI-1:0] lvl,
                                   input logic [4:0] func,
                                   input logic act_high);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_MFI; i++)
    begin
      if (sel[i] == func && lvl[i] == act_high)
      begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic [CUR_W-1:0] cmax(input logic [CUR_W-1:0] a,
                                            input logic [CUR_W-1:0] b);
    return (a > b) ? a : b;
  endfunction

  function automatic logic [CUR_W-1:0] cmin(input logic [CUR_W-1:0] a,
                                            input logic [CUR_W-1:0] b);
    return (a < b) ? a : b;
  endfunction

  logic [CUR_W-1:0] imax, imin;
  logic running;
  assign imax = cmax(cmax(phase_u_cur_i, phase_v_cur_i), phase_w_cur_i);
  assign imin = cmin(cmin(phase_u_cur_i, phase_v_cur_i), phase_w_cur_i);
  assign running = run_fx || run_rx;

  // Tick of 0.1 s; external fault inputs ignored until the synchroniser has filled
  logic [23:0] tick_cnt_r, tick_cnt_nxt;
  logic tick;
  logic [2:0] fill_cnt_r, fill_cnt_nxt;
  logic pins_ok;
  assign tick = (tick_cnt_r == 24'(TICK_CYC - 1));
  assign pins_ok = (fill_cnt_r >= 3'(SYNC_FILL));
  always_comb
  begin
    tick_cnt_nxt = tick ? 24'h000000 : tick_cnt_r + 24'h000001;
    fill_cnt_nxt = pins_ok ? fill_cnt_r : fill_cnt_r + 3'h1;
  end

  // Timed detectors
  logic [9:0] ol_cnt_r, ol_cnt_nxt;
  logic [7:0] rip_cnt_r, rip_cnt_nxt;
  logic [10:0] loss_cnt_r, loss_cnt_nxt;
  logic [10:0] wait_lim;
  logic [7:0] rip_lim;
  logic ol_hit, rip_hit, loss_hit;
  always_comb
  begin
    if (loss_wait_time_i < LOSS_WAIT_MIN)
    begin
      wait_lim = LOSS_WAIT_MIN;
    end
    else if (loss_wait_time_i > LOSS_WAIT_MAX)
    begin
      wait_lim = LOSS_WAIT_MAX;
    end
    else
    begin
      wait_lim = loss_wait_time_i;
    end
    // Heavier load shortens the ripple detection window
    if (imax >= OL_LIMIT)
    begin
      rip_lim = 8'(RIPPLE_BASE_TICKS / 3);
    end
    else if (imax >= 12'h064)
    begin
      rip_lim = 8'(RIPPLE_BASE_TICKS / 2);
    end
    else
    begin
      rip_lim = 8'(RIPPLE_BASE_TICKS);
    end
    ol_hit = (ol_cnt_r >= 10'(OL_TICKS));
    rip_hit = (rip_cnt_r >= rip_lim);
    loss_hit = (loss_cnt_r >= wait_lim);
    ol_cnt_nxt = ol_cnt_r;
    if (imax < OL_LIMIT)
    begin
      ol_cnt_nxt = 10'h000;
    end
    else if (tick && !ol_hit)
    begin
      ol_cnt_nxt = ol_cnt_r + 10'h001;
    end
    rip_cnt_nxt = rip_cnt_r;
    if (!bus_ripple_i)
    begin
      rip_cnt_nxt = 8'h00;
    end
    else if (tick && !rip_hit)
    begin
      rip_cnt_nxt = rip_cnt_r + 8'h01;
    end
    loss_cnt_nxt = loss_cnt_r;
    if (!freq_ref_remote_i || ref_ok)
    begin
      loss_cnt_nxt = 11'h000;
    end
    else if (tick && !loss_hit)
    begin
      loss_cnt_nxt = loss_cnt_r + 11'h001;
    end
  end

  // Live fault causes
  logic c_oc, c_gnd, c_ovl, c_mol, c_hot, c_rip, c_ph, c_ov, c_uv;
  logic c_ext_no, c_ext_nc, c_cut;
  always_comb
  begin
    c_oc = imax > OC_LIMIT;
    c_gnd = ground_fault_en_i && ground_fault_det_i;
    if (running && (imax - imin) > IMB_LIMIT && imax > OL_LIMIT)
    begin
      c_gnd = 1'b1;
    end
    c_ovl = ol_hit;
    c_mol = imax > motor_rated_current_setting_i;
    c_hot = heat_sink_over_i;
    c_rip = rip_hit;
    c_ph = out_phase_loss_en_i && running && imin < PH_OPEN_LIMIT
           && imax >= PH_OPEN_LIMIT;
    c_ov = dc_bus_volt_i > OV_LIMIT;
    c_uv = dc_bus_volt_i < UV_LIMIT;
    c_ext_no = pins_ok && mfi_hit(multifunction_input_select_i, mfi,
                       FUNC_EXT_NO, 1'b1);
    c_ext_nc = pins_ok && mfi_hit(multifunction_input_select_i, mfi,
                       FUNC_EXT_NC, 1'b0);
    c_cut = estop;
  end

  // Priority encoder of live causes
  dfts_code_e live_code;
  logic hot_in;
  assign hot_in = c_hot;
  always_comb
  begin
    live_code = FC_NONE;
    if (c_ext_nc) live_code = FC_EXT_NC;
    if (c_ext_no) live_code = FC_EXT_NO;
    if (param_save_fail_i) live_code = FC_PARAM_SAVE;
    if (c_mol) live_code = FC_MOTOR_OVERLOAD;
    if (c_ovl) live_code = FC_INV_OVERLOAD;
    if (c_rip) live_code = FC_RIPPLE;
    if (c_ph) live_code = FC_PHASE_LOSS;
    if (hot_in) live_code = FC_OVERHEAT;
    if (c_uv) live_code = FC_UNDERVOLT;
    if (c_ov) live_code = FC_OVERVOLT;
    if (c_gnd) live_code = FC_GROUND;
    if (c_oc) live_code = FC_OVERCURRENT;
  end

  function automatic logic cause_live(input dfts_code_e code,
                                      input logic [11:0] c);
    logic r;
    r = 1'b0;
    case (code)
      FC_OVERCURRENT: r = c[0];
      FC_GROUND: r = c[1];
      FC_OVERVOLT: r = c[2];
      FC_UNDERVOLT: r = c[3];
      FC_OVERHEAT: r = c[4];
      FC_PHASE_LOSS: r = c[5];
      FC_RIPPLE: r = c[6];
      FC_INV_OVERLOAD: r = c[7];
      FC_MOTOR_OVERLOAD: r = c[8];
      FC_PARAM_SAVE: r = c[9];
      FC_EXT_NO: r = c[10];
      FC_EXT_NC: r = c[11];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Fault latch state
  dfts_code_e latch_r, latch_nxt;
  logic hw_r, hw_nxt;
  logic rst_d_r, rst_edge;
  logic [11:0] cv;
  logic lost_act_r, lost_act_nxt;
  assign cv = {c_ext_nc, c_ext_no, param_save_fail_i, c_mol, c_ovl, c_rip,
               c_ph, hot_in, c_uv, c_ov, c_gnd, c_oc};
  assign rst_edge = rst_req && !rst_d_r;
  always_comb
  begin
    hw_nxt = hw_r | cpu_fault_i;
    latch_nxt = latch_r;
    if (latch_r == FC_NONE)
    begin
      latch_nxt = live_code;
    end
    else if (rst_edge && !cause_live(latch_r, cv))
    begin
      latch_nxt = live_code;
    end
    lost_act_nxt = loss_hit && freq_ref_remote_i && !ref_ok;
  end

  logic [CODE_W-1:0] code_nxt;
  logic gate_nxt, run_cmd;
  logic fault_any;
  assign run_cmd = run_fx || run_rx;
  assign fault_any = hw_r || (latch_r != FC_NONE) || (latch_nxt != FC_NONE);
  always_comb
  begin
    if (hw_r) code_nxt = FC_HW;
    else if (latch_nxt != FC_NONE) code_nxt = latch_nxt;
    else if (c_cut) code_nxt = FC_INSTANT_CUT;
    else code_nxt = FC_NONE;
    // Emergency cut is not latched, so release with run held resumes
    gate_nxt = run_cmd && !fault_any && !c_cut;
    if (lost_act_nxt && dfts_loss_e'(loss_action_select_i) == LA_FREE_RUN)
    begin
      gate_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (por_i)
    begin
      hw_r <= 1'b0;
    end
    else
    begin
      hw_r <= hw_nxt;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || por_i)
    begin
      tick_cnt_r <= 24'h000000;
      ol_cnt_r <= 10'h000;
      rip_cnt_r <= 8'h00;
      loss_cnt_r <= 11'h000;
      latch_r <= FC_NONE;
      rst_d_r <= 1'b0;
      lost_act_r <= 1'b0;
      fill_cnt_r <= 3'h0;
      gate_enable_o <= 1'b0;
      fault_code_o <= '0;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_nxt;
      ol_cnt_r <= ol_cnt_nxt;
      rip_cnt_r <= rip_cnt_nxt;
      loss_cnt_r <= loss_cnt_nxt;
      latch_r <= latch_nxt;
      rst_d_r <= rst_req;
      lost_act_r <= lost_act_nxt;
      fill_cnt_r <= fill_cnt_nxt;
      gate_enable_o <= gate_nxt;
      fault_code_o <= code_nxt;
    end
  end

  assign fault_active_o = (fault_code_o != FC_NONE);
  assign ref_lost_o = lost_act_r;
  assign hold_last_freq_o = lost_act_r &&
    (dfts_loss_e'(loss_action_select_i) == LA_CONTINUE);
  assign decel_stop_o = lost_act_r &&
    (dfts_loss_e'(loss_action_select_i) == LA_DECEL);
endmodule // dfts_top

/* File: verif/dfts_monitor.sv */
// Purpose: Port checks on the fault supervisor top.
// Assumes: Sensor causes reach the gate one cycle later.
// Notes: Terminal pins are allowed a few cycles of lag.
`timescale 1ns/100ps
module dfts_monitor
(
  // Clock and resets
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic por_i,
  // Causes
  input wire logic [dfts_pkg::CUR_W-1:0] phase_u_cur_i,
  input wire logic [dfts_pkg::CUR_W-1:0] phase_v_cur_i,
  input wire logic [dfts_pkg::CUR_W-1:0] phase_w_cur_i,
  input wire logic [dfts_pkg::VOLT_W-1:0] dc_bus_volt_i,
  input wire logic ground_fault_det_i,
  input wire logic heat_sink_over_i,
  input wire logic ground_fault_en_i,
  input wire logic param_save_fail_i,
  input wire logic [dfts_pkg::CUR_W-1:0] motor_rated_current_setting_i,
  input wire logic emergency_cut_input_i,
  input wire logic forward_run_input_i,
  input wire logic reverse_run_input_i,
  // Outputs
  input wire logic gate_enable_o,
  input wire logic [dfts_pkg::CODE_W-1:0] fault_code_o,
  input wire logic fault_active_o
);
  import dfts_pkg::*;
  logic oc;
  logic mol;
  assign oc = (phase_u_cur_i > OC_LIMIT) || (phase_v_cur_i > OC_LIMIT) ||
    (phase_w_cur_i > OC_LIMIT);
  assign mol = phase_u_cur_i > motor_rated_current_setting_i;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i || por_i);
  sequence s_cut_held;
    emergency_cut_input_i [*7];
  endsequence
  sequence s_cut_gone;
    $fell(emergency_cut_input_i) ##0 (fault_code_o == FC_INSTANT_CUT) ##0
      (forward_run_input_i || reverse_run_input_i);
  endsequence
  property p_hw_hold;
    @(posedge sys_clk_i) disable iff (srst_i || por_i)
      fault_code_o == FC_HW |=> fault_code_o == FC_HW;
  endproperty
  AST_OC_TRIP: assert property (oc
    |=> !gate_enable_o && fault_active_o)
    else $error("overcurrent kept gate on");
  AST_OH_TRIP: assert property (heat_sink_over_i
    |=> !gate_enable_o) else $error("overheat kept gate on");
  AST_GND_TRIP: assert property (ground_fault_en_i && ground_fault_det_i
    |=> !gate_enable_o) else $error("ground fault kept gate on");
  AST_MOL_TRIP: assert property (mol |=> !gate_enable_o)
    else $error("motor overload kept gate on");
  AST_OV_TRIP: assert property (dc_bus_volt_i > OV_LIMIT
    |=> !gate_enable_o) else $error("overvoltage kept gate on");
  AST_UV_TRIP: assert property (dc_bus_volt_i < UV_LIMIT
    |=> !gate_enable_o) else $error("undervoltage kept gate on");
  AST_SAVE_FLAG: assert property (param_save_fail_i
    |=> fault_active_o) else $error("save failure not flagged");
  AST_HW_HOLD: assert property (p_hw_hold)
    else $error("hardware fault code left");
  AST_CUT_BLOCK: assert property (s_cut_held |-> !gate_enable_o)
    else $error("cut input kept gate on");
  AST_CUT_RESUME: assert property (s_cut_gone
    |-> ##[1:12] gate_enable_o) else $error("no resume after cut");
  AST_CAUSE_KEEP: assert property (fault_active_o && oc
    |=> fault_active_o) else $error("fault cleared with cause present");
  AST_HOLD_LOW: assert property (fault_active_o &&
    fault_code_o != FC_PARAM_SAVE |-> !gate_enable_o)
    else $error("gate on while fault latched");
  AST_PRIO: assert property ($rose(fault_active_o) && $past(oc)
    |-> fault_code_o == FC_OVERCURRENT) else $error("wrong priority");
endmodule // dfts_monitor

/* File: verif/dfts_plant.sv */
// Purpose: Plant model: power stage sensors and terminals.
// Assumes: Levels change at the falling clock edge.
// Notes: Case 0 is healthy; case 11 applies two causes, other cases apply one cause.
`timescale 1ns/100ps
module dfts_plant
(
  // Clock
  input wire logic sys_clk_i,
  // Sensors
  output logic [dfts_pkg::CUR_W-1:0] cur_o [3],
  output logic [dfts_pkg::VOLT_W-1:0] volt_o,
  output logic gnd_o,
  output logic hot_o,
  output logic save_fail_o,
  output logic cpu_fault_o,
  // Terminals
  output logic cut_o,
  output logic [dfts_pkg::N_MFI-1:0] mfi_o
);
  import dfts_pkg::*;
  int k = 0;
  logic [CUR_W-1:0] ld = 12'h078;
  task automatic set_case(input int c, input logic [CUR_W-1:0] m);
    @(negedge sys_clk_i);
    k = c;
    ld = m;
  endtask
  always_comb
  begin
    cur_o = '{12'h032, 12'h032, 12'h032};
    volt_o = 10'h12C;
    gnd_o = 1'b0;
    hot_o = 1'b0;
    save_fail_o = 1'b0;
    cpu_fault_o = 1'b0;
    cut_o = 1'b0;
    mfi_o = 5'h10;
    case (k)
      1: cur_o[0] = 12'h0C9;
      2: gnd_o = 1'b1;
      3: cur_o = '{12'h0AA, 12'h014, 12'h014};
      4: cur_o = '{ld, ld, ld};
      5: volt_o = 10'h191;
      6: volt_o = 10'h0B3;
      7: save_fail_o = 1'b1;
      8: cur_o = '{12'h000, 12'h028, 12'h028};
      9: mfi_o[3] = 1'b1;
      10: mfi_o[4] = 1'b0;
      11:
      begin
        cur_o[0] = 12'h0C9;
        volt_o = 10'h191;
      end
      12: hot_o = 1'b1;
      13: cut_o = 1'b1;
      14: cpu_fault_o = 1'b1;
      default: ;
    endcase
  end
endmodule // dfts_plant

/* File: verif/dfts_top_bench.sv */
// Purpose: Self-checking bench for the fault supervisor.
// Assumes: Causes applied one at a time by the plant model, except case 11 which applies two.
// Notes: Long timers are not reached within the run length.
`timescale 1ns/100ps
bind dfts_top dfts_monitor i_dfts_monitor (.sys_clk_i, .srst_i, .por_i,
  .phase_u_cur_i, .phase_v_cur_i, .phase_w_cur_i, .dc_bus_volt_i,
  .ground_fault_det_i, .ground_fault_en_i, .param_save_fail_i,
  .motor_rated_current_setting_i, .emergency_cut_input_i,
  .forward_run_input_i, .reverse_run_input_i, .gate_enable_o,
  .fault_code_o, .fault_active_o, .heat_sink_over_i);
module dfts_top_bench;
  import dfts_pkg::*;
  logic sys_clk_i = 0, srst_i = 1, por_i = 1, fwd = 1, rev = 0, rt = 0;
  logic ref_ok = 1, gnd, hot, sf, cf, cut, gate, fa, rl, hl, dc;
  logic [CUR_W-1:0] cur [3];
  logic [VOLT_W-1:0] volt;
  logic [N_MFI-1:0] mfi;
  logic [1:0] la = 0;
  logic [10:0] lw = 11'h00A;
  logic [3:0] code, last = 0;
  logic [4:0] sel [N_MFI] = '{5'h00, 5'h00, 5'h00, FUNC_EXT_NO, FUNC_EXT_NC};
  dfts_code_e exq [$];
  dfts_code_e tab [13] = '{FC_NONE, FC_OVERCURRENT, FC_GROUND, FC_GROUND,
    FC_MOTOR_OVERLOAD, FC_OVERVOLT, FC_UNDERVOLT, FC_PARAM_SAVE,
    FC_PHASE_LOSS, FC_EXT_NO, FC_EXT_NC, FC_OVERCURRENT, FC_OVERHEAT};
  int n_errors = 0, checks_done = 0;
  initial forever #5 sys_clk_i = ~sys_clk_i;
  dfts_plant i_dfts_plant (.sys_clk_i, .cur_o(cur), .volt_o(volt),
    .gnd_o(gnd), .hot_o(hot), .save_fail_o(sf), .cpu_fault_o(cf),
    .cut_o(cut), .mfi_o(mfi));
  dfts_top i_dfts_top (.sys_clk_i, .srst_i, .por_i, .phase_u_cur_i(cur[0]),
    .phase_v_cur_i(cur[1]), .phase_w_cur_i(cur[2]), .dc_bus_volt_i(volt),
    .bus_ripple_i(1'b0), .ground_fault_det_i(gnd), .param_save_fail_i(sf),
    .heat_sink_over_i(hot),
    .cpu_fault_i(cf), .motor_rated_current_setting_i(12'h064),
    .ground_fault_en_i(1'b1), .out_phase_loss_en_i(1'b1),
    .multifunction_input_select_i(sel), .loss_action_select_i(la),
    .loss_wait_time_i(lw), .freq_ref_remote_i(1'b1),
    .emergency_cut_input_i(cut), .forward_run_input_i(fwd),
    .reverse_run_input_i(rev), .reset_terminal_i(rt), .mfi_pin_i(mfi),
    .freq_ref_present_i(ref_ok), .gate_enable_o(gate), .fault_code_o(code),
    .fault_active_o(fa), .ref_lost_o(rl), .hold_last_freq_o(hl),
    .decel_stop_o(dc));
  task automatic check(input string nm, input logic [7:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Selector: 0 fault_active, 1 gate, 2 queue empty
  task automatic wait_sig(input int s, input logic v);
    int n = 0;
    while ((s == 0 ? fa : s == 1 ? gate : exq.size() == 0) !== v && n < 300)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 300)
    begin
      check("timeout", 8'h01, 8'h00);
      end_sim();
    end
  endtask
  task automatic pulse_rst();
    repeat (8) @(negedge sys_clk_i);
    rt = 1;
    repeat (8) @(negedge sys_clk_i);
    rt = 0;
  endtask
  always @(negedge sys_clk_i)
  begin
    if (code !== last && code !== 4'h0)
      check("fault_code", code, exq.size() ? exq.pop_front() : 0);
    last <= code;
  end
  initial
  begin
    void'($urandom(32'h91F576FC));
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    srst_i = 0;
    por_i = 0;
    la = 2'($urandom_range(2));
    lw = LOSS_WAIT_MIN + 11'($urandom_range(1199));
    wait_sig(1, 1'b1);
    for (int c = 1; c < 13; c++)
    begin
      exq.push_back(tab[c]);
      i_dfts_plant.set_case(c, 12'h065 + 12'($urandom_range(47)));
      wait_sig(0, 1'b1);
      pulse_rst();
      check("held", fa, 1'b1);
      if (c != 7)
        check("gate", gate, 1'b0);
      i_dfts_plant.set_case(0, 12'h078);
      pulse_rst();
      wait_sig(0, 1'b0);
      wait_sig(1, 1'b1);
    end
    ref_ok = 0;
    repeat (20) @(negedge sys_clk_i);
    ref_ok = 1;
    check("ref_lost", rl, 1'b0);
    check("hold_last", hl, 1'b0);
    check("decel_stop", dc, 1'b0);
    fwd = 0;
    rev = 1;
    exq.push_back(FC_INSTANT_CUT);
    i_dfts_plant.set_case(13, 12'h078);
    wait_sig(1, 1'b0);
    wait_sig(2, 1'b1);
    i_dfts_plant.set_case(0, 12'h078);
    wait_sig(1, 1'b1);
    exq.push_back(FC_HW);
    i_dfts_plant.set_case(14, 12'h078);
    wait_sig(0, 1'b1);
    i_dfts_plant.set_case(0, 12'h078);
    pulse_rst();
    check("hw_code", code, FC_HW);
    por_i = 1;
    repeat (2) @(negedge sys_clk_i);
    por_i = 0;
    wait_sig(1, 1'b1);
    check("por_code", code, FC_NONE);
    check("queue", 8'(exq.size()), 8'h00);
    end_sim();
  end
endmodule // dfts_top_bench
